// [pkg/aimix_pkg.sv]
package aimix_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 8;
	localparam int          LEVEL_W         = 4;

	localparam logic [7:0]  OFF_MIX2        = 8'h12;
	localparam logic [7:0]  OFF_LEFT1       = 8'h13;
	localparam logic [7:0]  OFF_RSVD        = 8'h14;

	localparam logic [7:0]  RST_MIX2        = 8'hff;
	localparam logic [7:0]  RST_LEFT1       = 8'h78;
	localparam logic [7:0]  RSVD_VALUE      = 8'h78;
	localparam logic [7:0]  UNMAPPED_VALUE  = 8'h00;

	localparam int          MIX2_LEFT_LSB   = 4;
	localparam int          MIX2_RIGHT_LSB  = 0;
	localparam int          LEFT1_DIFF_BIT  = 7;
	localparam int          LEFT1_LEVEL_LSB = 3;
	localparam int          LEFT1_PWR_BIT   = 2;
	localparam int          LEFT1_SS_LSB    = 0;

	localparam logic [3:0]  LEVEL_MAX       = 4'h8;
	localparam logic [3:0]  LEVEL_OFF       = 4'hf;
	localparam logic [3:0]  ATTEN_NONE      = 4'h0;

	localparam logic [1:0]  SS_EVERY_ONE    = 2'h0;
	localparam logic [1:0]  SS_EVERY_TWO    = 2'h1;
endpackage : aimix_pkg

// [rtl/aimix_level_decode.sv]
`timescale 1ns/1ps
module aimix_level_decode (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [3:0] level,
	output logic            connect,
	output logic [3:0]      atten
);
	typedef struct packed {
		logic       connect;
		logic [3:0] atten;
	} aimix_dec_s;

	aimix_dec_s state_q;
	aimix_dec_s state_d;

	// Reserved codes count as disconnected so the mixer never sees an undefined step
	always_comb begin
		state_d = state_q;
		if (level <= aimix_pkg::LEVEL_MAX) begin
			state_d.connect = 1'b1;
			state_d.atten   = level;
		end else begin
			state_d.connect = 1'b0;
			state_d.atten   = aimix_pkg::ATTEN_NONE;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q.connect <= 1'b0;
			state_q.atten   <= aimix_pkg::ATTEN_NONE;
		end else begin
			state_q <= state_d;
		end
	end

	assign connect = state_q.connect;
	assign atten   = state_q.atten;

	property p_level_connect;
		@(posedge clk) disable iff (reset)
		(level <= 4'h8) |=> (connect && atten == $past(level));
	endproperty
	a_level_connect: assert property (p_level_connect)
		else $error("Valid level did not connect input with its step");

	property p_level_off;
		@(posedge clk) disable iff (reset)
		(level == 4'hf) |=> (!connect && atten == 4'h0);
	endproperty
	a_level_off: assert property (p_level_off)
		else $error("Off code left input connected");
endmodule : aimix_level_decode

// [rtl/aimix_ctrl_regs.sv]
`timescale 1ns/1ps
// Summary of operation
// - Upper nibble of reg 0x12 sets left second input level into right mixer.
// - Upper nibble 1111 disconnects left second input; resets to 1111.
// - Lower nibble of reg 0x12 sets right second input level, 0 to -12 dB.
// - Lower nibble 1111, the reset value, leaves right second input unconnected.
// - Reg 0x13 bit 7 picks single-ended (0, reset) or fully differential (1).
// - Reg 0x13 bits 6 to 3 set left first input level into left mixer.
// - Those bits at 1111, the reset value, disconnect the left first input.
// - Reg 0x13 bit 2 powers the left record channel; resets powered down.
// - Reg 0x13 bits 1 to 0 pick soft-step rate: 00, 01, or disabled.
// - Reg 0x14 is read-only, reads 0x78; host never writes it.
module aimix_ctrl_regs (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wr_data,
	output logic [7:0]      rd_data,
	output logic            rd_valid,
	output logic            rmix_left2_connect,
	output logic [3:0]      rmix_left2_atten,
	output logic            rmix_right2_connect,
	output logic [3:0]      rmix_right2_atten,
	output logic            lmix_left1_connect,
	output logic [3:0]      lmix_left1_atten,
	output logic            left1_differential,
	output logic            left_rec_power_up,
	output logic            left_soft_step_en,
	output logic            left_soft_step_half_rate
);
	typedef struct packed {
		logic [7:0] mix2;
		logic [7:0] left1;
		logic [7:0] rd_data;
		logic       rd_valid;
		logic       diff;
		logic       power;
		logic       ss_en;
		logic       ss_half;
	} aimix_regs_s;

	aimix_regs_s state_q;
	aimix_regs_s state_d;

	logic [2:0][3:0] levels;
	logic [2:0]      dec_connect;
	logic [2:0][3:0] dec_atten;

	always_comb begin
		state_d          = state_q;
		state_d.rd_valid = 1'b0;
		// Writes to the reserved word and to unmapped offsets are dropped
		if (wr_en) begin
			unique case (addr)
				aimix_pkg::OFF_MIX2:  state_d.mix2  = wr_data;
				aimix_pkg::OFF_LEFT1: state_d.left1 = wr_data;
				default: ;
			endcase
		end
		if (rd_en) begin
			state_d.rd_valid = 1'b1;
			unique case (addr)
				aimix_pkg::OFF_MIX2:  state_d.rd_data = state_q.mix2;
				aimix_pkg::OFF_LEFT1: state_d.rd_data = state_q.left1;
				aimix_pkg::OFF_RSVD:  state_d.rd_data = aimix_pkg::RSVD_VALUE;
				default:              state_d.rd_data = aimix_pkg::UNMAPPED_VALUE;
			endcase
		end
		state_d.diff  = state_q.left1[aimix_pkg::LEFT1_DIFF_BIT];
		state_d.power = state_q.left1[aimix_pkg::LEFT1_PWR_BIT];
		// Codes 10 and 11 both disable stepping; the rate flag then has no meaning
		unique case (state_q.left1[aimix_pkg::LEFT1_SS_LSB +: 2])
			aimix_pkg::SS_EVERY_ONE: begin
				state_d.ss_en   = 1'b1;
				state_d.ss_half = 1'b0;
			end
			aimix_pkg::SS_EVERY_TWO: begin
				state_d.ss_en   = 1'b1;
				state_d.ss_half = 1'b1;
			end
			default: begin
				state_d.ss_en   = 1'b0;
				state_d.ss_half = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q.mix2     <= aimix_pkg::RST_MIX2;
			state_q.left1    <= aimix_pkg::RST_LEFT1;
			state_q.rd_data  <= aimix_pkg::UNMAPPED_VALUE;
			state_q.rd_valid <= 1'b0;
			state_q.diff     <= 1'b0;
			state_q.power    <= 1'b0;
			state_q.ss_en    <= 1'b1;
			state_q.ss_half  <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// Host is trusted to keep reserved codes out; they decode as disconnected
	assign levels[0] = state_q.mix2[aimix_pkg::MIX2_LEFT_LSB +: aimix_pkg::LEVEL_W];
	assign levels[1] = state_q.mix2[aimix_pkg::MIX2_RIGHT_LSB +: aimix_pkg::LEVEL_W];
	assign levels[2] = state_q.left1[aimix_pkg::LEFT1_LEVEL_LSB +: aimix_pkg::LEVEL_W];

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_level
			aimix_level_decode u_dec (
				.clk     (clk),
				.reset   (reset),
				.level   (levels[gi]),
				.connect (dec_connect[gi]),
				.atten   (dec_atten[gi])
			);
		end
	endgenerate

	assign rd_data                  = state_q.rd_data;
	assign rd_valid                 = state_q.rd_valid;
	assign rmix_left2_connect       = dec_connect[0];
	assign rmix_left2_atten         = dec_atten[0];
	assign rmix_right2_connect      = dec_connect[1];
	assign rmix_right2_atten        = dec_atten[1];
	assign lmix_left1_connect       = dec_connect[2];
	assign lmix_left1_atten         = dec_atten[2];
	assign left1_differential       = state_q.diff;
	assign left_rec_power_up        = state_q.power;
	assign left_soft_step_en        = state_q.ss_en;
	assign left_soft_step_half_rate = state_q.ss_half;

	property p_write_readback;
		@(posedge clk) disable iff (reset)
		(wr_en && addr == 8'h12) ##1 (rd_en && !wr_en && addr == 8'h12)
			|=> (rd_valid && rd_data == $past(wr_data, 2));
	endproperty
	a_write_readback: assert property (p_write_readback)
		else $error("Register 0x12 did not read back written value");

	property p_rsvd_read;
		@(posedge clk) disable iff (reset)
		(rd_en && addr == 8'h14) |=> (rd_valid && rd_data == 8'h78);
	endproperty
	a_rsvd_read: assert property (p_rsvd_read)
		else $error("Reserved register did not read 0x78");

	property p_diff_follow;
		@(posedge clk) disable iff (reset)
		(wr_en && addr == 8'h13) |=> ##1 (left1_differential == $past(wr_data[7], 2));
	endproperty
	a_diff_follow: assert property (p_diff_follow)
		else $error("Differential select did not follow bit 7");

	property p_power_follow;
		@(posedge clk) disable iff (reset)
		(wr_en && addr == 8'h13) |=> ##1 (left_rec_power_up == $past(wr_data[2], 2));
	endproperty
	a_power_follow: assert property (p_power_follow)
		else $error("Left record power did not follow bit 2");

	property p_soft_step;
		@(posedge clk) disable iff (reset)
		(wr_en && addr == 8'h13 && wr_data[1]) |=> ##1 (!left_soft_step_en && !left_soft_step_half_rate);
	endproperty
	a_soft_step: assert property (p_soft_step)
		else $error("Soft-stepping not disabled for codes 10 or 11");

	property p_reset_state;
		@(posedge clk) disable iff (reset)
		$fell(reset) |-> (!rmix_left2_connect && !rmix_right2_connect && !lmix_left1_connect
			&& !left1_differential && !left_rec_power_up && left_soft_step_en);
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("Outputs not at reset state after reset");

	property p_unmapped_write;
		@(posedge clk) disable iff (reset)
		(wr_en && addr != aimix_pkg::OFF_MIX2 && addr != aimix_pkg::OFF_LEFT1)
			|=> ($stable(state_q.mix2) && $stable(state_q.left1));
	endproperty
	a_unmapped_write: assert property (p_unmapped_write)
		else $error("Write to unmapped or reserved offset changed a register");

	property p_rd_valid_pulse;
		@(posedge clk) disable iff (reset)
		1'b1 |=> (rd_valid == $past(rd_en));
	endproperty
	a_rd_valid_pulse: assert property (p_rd_valid_pulse)
		else $error("Read valid did not follow read strobe by one cycle");

	property p_same_cycle_old;
		@(posedge clk) disable iff (reset)
		(wr_en && rd_en && addr == aimix_pkg::OFF_LEFT1) |=> (rd_data == $past(state_q.left1));
	endproperty
	a_same_cycle_old: assert property (p_same_cycle_old)
		else $error("Read during write did not return the old value");

	property p_left1_level;
		@(posedge clk) disable iff (reset)
		(wr_en && addr == aimix_pkg::OFF_LEFT1 && wr_data[6:3] <= aimix_pkg::LEVEL_MAX)
			|=> ##1 (lmix_left1_connect && lmix_left1_atten == $past(wr_data[6:3], 2));
	endproperty
	a_left1_level: assert property (p_left1_level)
		else $error("Left first input level not routed to left mixer");

	property p_right2_off;
		@(posedge clk) disable iff (reset)
		(wr_en && addr == aimix_pkg::OFF_MIX2 && wr_data[3:0] == aimix_pkg::LEVEL_OFF)
			|=> ##1 !rmix_right2_connect;
	endproperty
	a_right2_off: assert property (p_right2_off)
		else $error("Right second input stayed connected on off code");

	property p_left2_off;
		@(posedge clk) disable iff (reset)
		(wr_en && addr == aimix_pkg::OFF_MIX2 && wr_data[7:4] == aimix_pkg::LEVEL_OFF)
			|=> ##1 !rmix_left2_connect;
	endproperty
	a_left2_off: assert property (p_left2_off)
		else $error("Left second input stayed connected on off code");

	property p_half_rate;
		@(posedge clk) disable iff (reset)
		(wr_en && addr == aimix_pkg::OFF_LEFT1 && wr_data[1:0] == aimix_pkg::SS_EVERY_TWO)
			|=> ##1 (left_soft_step_en && left_soft_step_half_rate);
	endproperty
	a_half_rate: assert property (p_half_rate)
		else $error("Soft-step code 01 did not select half rate");
endmodule : aimix_ctrl_regs

// [verif/aimix_host.sv]
`timescale 1ns/1ps
module aimix_host (
	input  wire logic       clk,
	output logic            wr_en,
	output logic            rd_en,
	output logic [7:0]      addr,
	output logic [7:0]      wr_data,
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_valid
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wr_data = 8'h00;
	end
	// Callers pass level codes 0 to 8 or f only, with both single-ended and differential inputs
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		if (a == aimix_pkg::OFF_RSVD) return;
		@(posedge clk);
		#1;
		wr_en = 1'b1;
		addr = a;
		wr_data = d;
		@(posedge clk);
		#1;
		wr_en = 1'b0;
		addr = ~a;
		wr_data = ~d;
	endtask : write
	task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk);
		#1;
		rd_en = 1'b1;
		addr = a;
		@(posedge clk);
		#1;
		d = rd_data;
		v = rd_valid;
		rd_en = 1'b0;
		addr = ~a;
	endtask : read
	// One bus cycle; caller starts just after an edge and ends with an idle call
	task automatic drive(input logic w, input logic r, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic v);
		wr_en = w;
		rd_en = r;
		addr = a;
		wr_data = d;
		@(posedge clk);
		#1;
		q = rd_data;
		v = rd_valid;
	endtask : drive
endmodule : aimix_host

// [verif/adc_input_mix_control_regs_test.sv]
`timescale 1ns/1ps
module adc_input_mix_control_regs_test;
	logic       clk = 1'b0;
	logic       reset = 1'b1;
	logic       wr_en, rd_en, rd_valid;
	logic [7:0] addr, wr_data, rd_data;
	logic       rmix_left2_connect, rmix_right2_connect, lmix_left1_connect;
	logic [3:0] rmix_left2_atten, rmix_right2_atten, lmix_left1_atten;
	logic       left1_differential, left_rec_power_up;
	logic       left_soft_step_en, left_soft_step_half_rate;
	int         bad_count = 0;
	int         check_count = 0;
	wire [9:0]  mix_o = {rmix_left2_connect, rmix_left2_atten, rmix_right2_connect,
		rmix_right2_atten};
	wire [8:0]  left_o = {left1_differential, lmix_left1_connect, lmix_left1_atten,
		left_rec_power_up, left_soft_step_en, left_soft_step_half_rate};
	always #12.5 clk = ~clk;
	aimix_ctrl_regs DUT (.clk, .reset, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .rd_valid,
		.rmix_left2_connect, .rmix_left2_atten, .rmix_right2_connect, .rmix_right2_atten,
		.lmix_left1_connect, .lmix_left1_atten, .left1_differential, .left_rec_power_up,
		.left_soft_step_en, .left_soft_step_half_rate);
	aimix_host host (.clk, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .rd_valid);
	function automatic logic [4:0] lvl(input logic [3:0] c);
		return (c <= 4'h8) ? {1'b1, c} : 5'h00;
	endfunction : lvl
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       v;
		host.read(a, d, v);
		chk("rd_valid", 16'h1, {15'h0, v});
		chk("rd_data", {8'h00, e}, {8'h00, d});
	endtask : rdchk
	task automatic wr_settle(input logic [7:0] a, input logic [7:0] d);
		host.write(a, d);
		repeat (2) @(posedge clk);
		#1;
	endtask : wr_settle
	task automatic t_reset;
		rdchk(8'h12, 8'hff);
		rdchk(8'h13, 8'h78);
		rdchk(8'h14, 8'h78);
		chk("mix outputs", 16'h0, {6'h0, mix_o});
		chk("left outputs", 16'h2, {7'h0, left_o});
		$display("test reset done");
	endtask : t_reset
	task automatic t_mix_levels;
		for (int k = 0; k <= 8; k++) begin
			wr_settle(8'h12, {4'(k), 4'(8 - k)});
			chk("mix levels", {6'h0, lvl(4'(k)), lvl(4'(8 - k))}, {6'h0, mix_o});
			rdchk(8'h12, {4'(k), 4'(8 - k)});
		end
		$display("test mix levels done");
	endtask : t_mix_levels
	task automatic t_left_ctrl;
		logic [7:0] d;
		for (int k = 0; k < 4; k++) begin
			d = {k[0], 4'(k + 5), ~k[0], 2'(k)};
			wr_settle(8'h13, d);
			chk("left ctrl", {7'h0, d[7], lvl(d[6:3]), d[2], k < 2, k == 1},
				{7'h0, left_o});
			rdchk(8'h13, d);
		end
		$display("test left control done");
	endtask : t_left_ctrl
	task automatic t_disconnect;
		wr_settle(8'h12, 8'hf0);
		chk("left2 off", 16'h010, {6'h0, mix_o});
		wr_settle(8'h12, 8'h0f);
		chk("right2 off", 16'h200, {6'h0, mix_o});
		wr_settle(8'h13, 8'hfc);
		chk("left1 off", 16'h106, {7'h0, left_o});
		rdchk(8'h14, 8'h78);
		$display("test disconnect done");
	endtask : t_disconnect
	// Strobes every cycle, no idle gap, so stale read data cannot hide a missed update
	task automatic t_back_to_back;
		logic [7:0] q;
		logic       v;
		@(posedge clk);
		#1;
		host.drive(1'b1, 1'b0, 8'h12, 8'h35, q, v);
		host.drive(1'b0, 1'b1, 8'h12, 8'h35, q, v);
		chk("b2b read 12", 16'h0135, {7'h0, v, q});
		host.drive(1'b1, 1'b1, 8'h13, 8'h85, q, v);
		chk("same cycle read", 16'h01fc, {7'h0, v, q});
		host.drive(1'b1, 1'b0, 8'h15, 8'h00, q, v);
		host.drive(1'b0, 1'b1, 8'h15, 8'h00, q, v);
		chk("unmapped read", 16'h0100, {7'h0, v, q});
		host.drive(1'b0, 1'b1, 8'h13, 8'h00, q, v);
		chk("b2b read 13", 16'h0185, {7'h0, v, q});
		host.drive(1'b0, 1'b1, 8'h12, 8'h00, q, v);
		chk("unmapped write", 16'h0135, {7'h0, v, q});
		host.drive(1'b0, 1'b0, 8'h00, 8'h00, q, v);
		chk("rd_valid drop", 16'h0, {15'h0, v});
		chk("b2b left", 16'h187, {7'h0, left_o});
		chk("b2b mix", 16'h275, {6'h0, mix_o});
		$display("test back to back done");
	endtask : t_back_to_back
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		#(25 * 5000);
		bad_count++;
		stop_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		#1;
		reset = 1'b0;
		t_reset();
		t_mix_levels();
		t_left_ctrl();
		t_disconnect();
		t_back_to_back();
		stop_test();
	end
endmodule : adc_input_mix_control_regs_test
